/* design/sensor_command_pkg.sv */
// constants and types shared by the sensor command responder
package sensor_command_pkg;
  localparam int unsigned CLOCK_HZ        = 100_000_000;
  localparam int unsigned LOCAL_CONV_MS   = 12;
  localparam int unsigned REMOTE_CONV_MS  = 38;
  localparam int unsigned LOCAL_CONV_CYC  = CLOCK_HZ / 1000 * LOCAL_CONV_MS;
  localparam int unsigned REMOTE_CONV_CYC = CLOCK_HZ / 1000 * REMOTE_CONV_MS;
  localparam int unsigned AVG_SHIFT       = 4;
  localparam logic [4:0]  AVG_COUNT       = 5'h10;
  localparam int unsigned ADC_BITS        = 10;
  localparam int unsigned ADC_LSB_SHIFT   = 2;

  // command codes
  localparam logic [7:0] CODE_LOCAL_TEMP   = 8'h00;
  localparam logic [7:0] CODE_REMOTE1_TEMP = 8'h01;
  localparam logic [7:0] CODE_REMOTE2_TEMP = 8'h02;
  localparam logic [7:0] CODE_QUIET_A      = 8'h09;
  localparam logic [7:0] CODE_SUPPLY_VOLT  = 8'h12;
  localparam logic [7:0] CODE_RAIL25_VOLT  = 8'h13;
  localparam logic [7:0] CODE_CORE_VOLT    = 8'h14;
  localparam logic [7:0] CODE_QUIET_LO     = 8'h15;
  localparam logic [7:0] CODE_QUIET_HI     = 8'hDF;
  localparam logic [7:0] CODE_CORR1        = 8'hE0;
  localparam logic [7:0] CODE_CORR2        = 8'hE1;
  localparam logic [7:0] CODE_RSVD_LO      = 8'hE2;
  localparam logic [7:0] CODE_RSVD_HI      = 8'hEE;

  // lengths
  localparam logic [7:0] LEN_QUERY = 8'h01;
  localparam logic [7:0] LEN_SET   = 8'h03;
  localparam logic [7:0] LEN_WORD  = 8'h02;
  localparam logic [7:0] LEN_BLOCK = 8'h06;

  localparam logic [15:0] DIODE_FAULT  = 16'h8000;
  localparam logic [15:0] ZERO_WORD    = 16'h0000;
  localparam logic [15:0] VOLT_FULL    = 16'h1000;  // 4.0 V in 1/1024 V
  localparam logic [15:0] CORR_MAX     = 16'h2000;  // +128 degrees
  localparam logic [15:0] CORR_MIN     = 16'hE000;  // -128 degrees
  localparam logic [15:0] CORR_STEP    = 16'h0010;  // 0.25 degree grain

  typedef enum logic [1:0] {
    CONV_LOCAL   = 2'b00,
    CONV_REMOTE1 = 2'b01,
    CONV_REMOTE2 = 2'b10
  } conv_chan_t;

  typedef enum logic [1:0] {
    LINK_IDLE  = 2'b00,
    LINK_DATA  = 2'b01,
    LINK_REPLY = 2'b10
  } link_state_t;
endpackage

/* design/sensor_command_responder.sv */
// command interpreter and conversion sequencer for the sensor
`timescale 1ns/1ps
`default_nettype none
module sensor_command_responder
  import sensor_command_pkg::*;
#(
  parameter int unsigned LOCAL_CYCLES  = LOCAL_CONV_CYC,
  parameter int unsigned REMOTE_CYCLES = REMOTE_CONV_CYC
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // command side from link framing
  input  wire logic        cmd_start,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [7:0]  cmd_write_len,
  input  wire logic [7:0]  cmd_read_len,
  input  wire logic        wr_valid,
  input  wire logic [7:0]  wr_byte,
  // reply side to link framing
  output logic             rd_valid,
  output logic [7:0]       rd_byte,
  input  wire logic        rd_ready,
  output logic             reply_done,
  output logic             reply_fcs_bad,
  // shared converter
  output logic [2:0]       adc_select,
  output logic             adc_start,
  input  wire logic        adc_done,
  input  wire logic [9:0]  adc_value,
  input  wire logic        diode1_fault,
  input  wire logic        diode2_fault
);
  import sensor_command_pkg::*;

  typedef struct packed {
    link_state_t  link;
    logic [7:0]   code;
    logic [7:0]   wlen;
    logic [7:0]   rlen;
    logic [2:0]   bidx;
    logic [7:0]   lo_byte;
    logic [1:0]   wcount;
    logic         fcs_bad;
    logic         rd_valid;
    logic [7:0]   rd_byte;
    logic         reply_done;
    logic         reply_fcs_bad;
    logic [15:0]  corr1;
    logic [15:0]  corr2;
    logic [15:0]  temp0;
    logic [15:0]  temp1;
    logic [15:0]  temp2;
    logic [15:0]  volt0;
    logic [15:0]  volt1;
    logic [15:0]  volt2;
    conv_chan_t   tchan;
    logic [1:0]   vchan;
    logic         phase_volt;
    logic [4:0]   avg_n;
    logic [19:0]  acc;
    logic [22:0]  timer;
    logic         busy;
    logic [2:0]   adc_select;
    logic         adc_start;
  } state_t;

  state_t cur, nxt;

  function automatic logic [15:0] word_at(input state_t s, input logic [2:0] idx);
    logic [7:0] base;
    logic [1:0] slot;
    base = s.code;
    slot = 2'(idx >> 1);
    word_at = ZERO_WORD;
    if (base == CODE_LOCAL_TEMP && s.rlen == LEN_BLOCK) begin
      case (slot)
        2'd0:    word_at = s.temp0;
        2'd1:    word_at = s.temp1;
        default: word_at = s.temp2;
      endcase
    end else if (base == CODE_SUPPLY_VOLT && s.rlen == LEN_BLOCK) begin
      case (slot)
        2'd0:    word_at = s.volt0;
        2'd1:    word_at = s.volt1;
        default: word_at = s.volt2;
      endcase
    end else begin
      case (base)
        CODE_LOCAL_TEMP:   word_at = s.temp0;
        CODE_REMOTE1_TEMP: word_at = s.temp1;
        CODE_REMOTE2_TEMP: word_at = s.temp2;
        CODE_SUPPLY_VOLT:  word_at = s.volt0;
        CODE_RAIL25_VOLT:  word_at = s.volt1;
        CODE_CORE_VOLT:    word_at = s.volt2;
        CODE_CORR1:        word_at = s.corr1;
        CODE_CORR2:        word_at = s.corr2;
        default:           word_at = ZERO_WORD;
      endcase
    end
  endfunction

  // clamp and quantise an incoming correction
  function automatic logic [15:0] corr_fix(input logic [15:0] v);
    logic [15:0] r;
    r = v;
    if (!v[15] && v > CORR_MAX) begin
      r = CORR_MAX;
    end else if (v[15] && v < CORR_MIN) begin
      r = CORR_MIN;
    end
    corr_fix = r & ~(CORR_STEP - 16'h0001);
    return corr_fix;
  endfunction

  logic [15:0] word_now;
  logic [15:0] avg_word;
  logic [15:0] volt_word;
  logic [15:0] wr_word;

  always_comb begin
    nxt = cur;
    nxt.adc_start  = 1'b0;
    nxt.reply_done = 1'b0;
    word_now  = word_at(cur, cur.bidx);
    wr_word   = {wr_byte, cur.lo_byte};
    avg_word  = cur.acc[19:AVG_SHIFT];
    volt_word = {6'h00, adc_value} << ADC_LSB_SHIFT;
    if (volt_word > VOLT_FULL) begin
      volt_word = VOLT_FULL;
    end

    // command link
    case (cur.link)
      LINK_IDLE: begin
        if (cmd_start) begin
          nxt.code    = cmd_code;
          nxt.wlen    = cmd_write_len;
          nxt.rlen    = cmd_read_len;
          nxt.bidx    = 3'd0;
          nxt.wcount  = 2'd0;
          nxt.fcs_bad = (cmd_write_len > LEN_QUERY) &&
                        (cmd_code >= CODE_RSVD_LO) && (cmd_code <= CODE_RSVD_HI);
          nxt.link    = (cmd_write_len > LEN_QUERY) ? LINK_DATA : LINK_REPLY;
        end
      end
      LINK_DATA: begin
        if (wr_valid) begin
          nxt.wcount  = 2'(cur.wcount + 2'd1);
          nxt.lo_byte = wr_byte;
          if (cur.wcount == 2'd1) begin
            // writable only at the two correction codes, length 3
            if (cur.wlen == LEN_SET && cur.code == CODE_CORR1) begin
              nxt.corr1 = corr_fix(wr_word);
            end else if (cur.wlen == LEN_SET && cur.code == CODE_CORR2) begin
              nxt.corr2 = corr_fix(wr_word);
            end
            // all other codes ignored, reserved codes flagged by a bad check value
            nxt.link = LINK_REPLY;
          end
        end
      end
      LINK_REPLY: begin
        if (cur.wlen <= LEN_QUERY && cur.bidx < cur.rlen[2:0] && cur.rlen <= LEN_BLOCK) begin
          if (!cur.rd_valid || rd_ready) begin
            nxt.rd_valid = 1'b1;
            nxt.rd_byte  = cur.bidx[0] ? word_now[15:8] : word_now[7:0];  // low byte first
            nxt.bidx     = 3'(cur.bidx + 3'd1);
          end
        end else if (!cur.rd_valid || rd_ready) begin
          nxt.rd_valid      = 1'b0;
          nxt.reply_done    = 1'b1;
          nxt.reply_fcs_bad = cur.fcs_bad;
          nxt.link          = LINK_IDLE;
        end
      end
      default: nxt.link = LINK_IDLE;
    endcase
    if (cur.link == LINK_IDLE && cur.rd_valid && rd_ready) begin
      nxt.rd_valid = 1'b0;
    end

    // conversion sequencer on the shared converter
    if (!cur.busy) begin
      nxt.busy      = 1'b1;
      nxt.adc_start = 1'b1;
      nxt.adc_select = cur.phase_volt ? 3'(3'd3 + {1'b0, cur.vchan}) : {1'b0, cur.tchan};
    end else begin
      if (nxt.timer != '1) begin
        nxt.timer = 23'(cur.timer + 23'd1);
      end
      if (adc_done) begin
        nxt.busy = 1'b0;
        if (cur.phase_volt) begin
          case (cur.vchan)
            2'd0:    nxt.volt0 = volt_word;
            2'd1:    nxt.volt1 = volt_word;
            default: nxt.volt2 = volt_word;
          endcase
          nxt.vchan      = (cur.vchan == 2'd2) ? 2'd0 : 2'(cur.vchan + 2'd1);
          nxt.phase_volt = 1'b0;
          // temperature slot time starts after the voltage conversion
          nxt.timer      = '0;
        end else if (cur.avg_n < AVG_COUNT) begin
          // gather exactly sixteen results per slot
          nxt.acc   = 20'(cur.acc + {10'h000, adc_value});
          nxt.avg_n = 5'(cur.avg_n + 5'd1);
        end
      end
      // temperature slot ends after its conversion time
      if (!cur.phase_volt && cur.timer >= 23'(cur.tchan == CONV_LOCAL ? LOCAL_CYCLES : REMOTE_CYCLES)) begin
        nxt.busy = 1'b0;
        nxt.timer = '0;
        if (cur.avg_n >= AVG_COUNT) begin
          nxt.acc   = '0;
          nxt.avg_n = 5'd0;
          case (cur.tchan)  // whole word stored at once
            CONV_LOCAL:   nxt.temp0 = avg_word;
            CONV_REMOTE1: nxt.temp1 = diode1_fault ? DIODE_FAULT : 16'(avg_word + cur.corr1);
            default:      nxt.temp2 = diode2_fault ? DIODE_FAULT : 16'(avg_word + cur.corr2);
          endcase
          case (cur.tchan)
            CONV_LOCAL:   nxt.tchan = CONV_REMOTE1;
            CONV_REMOTE1: nxt.tchan = CONV_REMOTE2;
            default:      nxt.tchan = CONV_LOCAL;
          endcase
          nxt.phase_volt = 1'b1;
        end
      end else if (!cur.phase_volt && adc_done) begin
        nxt.busy = 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  assign rd_valid      = cur.rd_valid;
  assign rd_byte       = cur.rd_byte;
  assign reply_done    = cur.reply_done;
  assign reply_fcs_bad = cur.reply_fcs_bad;
  assign adc_select    = cur.adc_select;
  assign adc_start     = cur.adc_start;
endmodule
`default_nettype wire

/* verification/sensor_command_props.sv */
// concurrent checks on the sensor command responder ports
`timescale 1ns/1ps
`default_nettype none
module sensor_command_props (
  // clock and reset
  input wire logic       clock,
  input wire logic       nrst,
  // command and reply side
  input wire logic       cmd_start,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_write_len,
  input wire logic [7:0] cmd_read_len,
  input wire logic       rd_valid,
  input wire logic [7:0] rd_byte,
  input wire logic       rd_ready,
  input wire logic       reply_done,
  input wire logic       reply_fcs_bad,
  // converter side
  input wire logic [2:0] adc_select,
  input wire logic       adc_start
);
  logic       busy;
  logic [7:0] code, wlen, rlen, nbytes;
  wire logic  take = cmd_start && !busy;
  // captures the accepted header and counts reply bytes
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      busy   <= 1'b0;
      code   <= 8'h00;
      wlen   <= 8'h00;
      rlen   <= 8'h00;
      nbytes <= 8'h00;
    end else begin
      if (take) begin
        busy   <= 1'b1;
        code   <= cmd_code;
        wlen   <= cmd_write_len;
        rlen   <= cmd_read_len;
        nbytes <= 8'h00;
      end else if (reply_done) begin
        busy <= 1'b0;
      end
      if (rd_valid && rd_ready) nbytes <= nbytes + 8'h01;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  a_start_one_cycle:
    assert property (adc_start |=> !adc_start) else $error("converter start held too long");
  a_select_in_range:
    assert property (adc_start |-> adc_select <= 3'h5) else $error("converter select out of range");
  a_done_one_cycle:
    assert property (reply_done |=> !reply_done) else $error("reply done held too long");
  a_byte_held:
    assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_byte)) else $error("reply byte dropped");
  a_read_answer:
    assert property (take && cmd_write_len == 8'h01 && cmd_read_len == 8'h02 &&
      cmd_code inside {[8'h00:8'h02], [8'h12:8'h14], 8'hE0, 8'hE1} |-> ##2 rd_valid) else $error("read not answered");
  a_byte_count:
    assert property (reply_done && wlen == 8'h01 && rlen inside {8'h02, 8'h06} |-> nbytes == rlen)
      else $error("reply byte count wrong");
  a_write_silent:
    assert property (busy && wlen == 8'h03 |-> !rd_valid) else $error("write returned data");
  a_reserved_bad:
    assert property (reply_done && wlen == 8'h03 && code inside {[8'hE2:8'hEE]} |-> reply_fcs_bad)
      else $error("reserved write check value good");
  a_unused_good:
    assert property (reply_done && wlen == 8'h03 && code inside {8'h02, 8'h09, [8'h15:8'hDF]} |-> !reply_fcs_bad)
      else $error("ignored write check value bad");
  c_block:  cover property (reply_done && rlen == 8'h06);
  c_write:  cover property (reply_done && wlen == 8'h03 && code == 8'hE0);
  c_stall:  cover property (rd_valid && !rd_ready);
endmodule
bind sensor_command_responder sensor_command_props props (.clock, .nrst, .cmd_start, .cmd_code, .cmd_write_len,
  .cmd_read_len, .rd_valid, .rd_byte, .rd_ready, .reply_done, .reply_fcs_bad, .adc_select, .adc_start);
`default_nettype wire

/* verification/converter_model.sv */
// shared converter model answering the latest start after a set lag, a new start restarting the count
`timescale 1ns/1ps
`default_nettype none
module converter_model #(
  parameter logic [2:0] LAG = 3'h4
) (
  // converter handshake
  input  wire logic       clock,
  input  wire logic [2:0] adc_select,
  input  wire logic       adc_start,
  output logic            adc_done,
  output logic [9:0]      adc_value
);
  logic [2:0] sel;
  logic [2:0] left;
  initial begin
    adc_done  = 1'b0;
    adc_value = 10'h3FF;
    sel       = 3'h0;
    left      = 3'h0;
  end
  // result lines toggle outside the done cycle
  always @(posedge clock) begin
    adc_done  <= 1'b0;
    adc_value <= ~adc_value;
    if (adc_start) begin
      sel  <= adc_select;
      left <= LAG;
    end else if (left != 3'h0) begin
      left <= left - 3'h1;
      if (left == 3'h1) begin
        adc_done  <= 1'b1;
        adc_value <= {sel, 7'h2B};
      end
    end
  end
endmodule
`default_nettype wire

/* verification/testbench.sv */
// self-checking bench for the sensor command responder
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sensor_command_pkg::*;
  logic        clock, nrst, cmd_start, wr_valid, rd_ready, diode1_fault, diode2_fault;
  logic [7:0]  cmd_code, cmd_write_len, cmd_read_len, wr_byte, rd_byte, code;
  logic        rd_valid, reply_done, reply_fcs_bad, adc_start, adc_done;
  logic [2:0]  adc_select;
  logic [9:0]  adc_value;
  logic [1:0]  ph;
  logic [31:0] lfsr = 32'h4BD992C6;
  logic [15:0] corr [2];
  logic [15:0] expq [$];
  logic [7:0]  codes [8] = '{8'h02, 8'h09, 8'h15, 8'hDF, 8'h00, 8'hE2, 8'hE8, 8'hEE};
  int          num_errors = 0;
  int          samples_checked = 0;
  sensor_command_responder #(.LOCAL_CYCLES(200), .REMOTE_CYCLES(200)) DUT (.clock, .nrst, .cmd_start, .cmd_code,
    .cmd_write_len, .cmd_read_len, .wr_valid, .wr_byte, .rd_valid, .rd_byte, .rd_ready, .reply_done,
    .reply_fcs_bad, .adc_select, .adc_start, .adc_done, .adc_value, .diode1_fault, .diode2_fault);
  converter_model adc (.clock, .adc_select, .adc_start, .adc_done, .adc_value);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[30:0], ^(lfsr & 32'h80200003)};
    return lfsr[15:0];
  endfunction
  function automatic logic [15:0] temp(input int c);
    logic [15:0] r;
    r = {6'h00, c[2:0], 7'h2B};
    if ((c == 1 && diode1_fault) || (c == 2 && diode2_fault)) return DIODE_FAULT;
    return (c == 0) ? r : r + corr[c - 1];
  endfunction
  function automatic logic [15:0] clampc(input logic [15:0] v);
    if ($signed(v) > $signed(CORR_MAX)) v = CORR_MAX;
    else if ($signed(v) < $signed(CORR_MIN)) v = CORR_MIN;
    return v & 16'hFFF0;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic expw(input logic [15:0] w);
    expq.push_back({8'h00, w[7:0]});
    expq.push_back({8'h00, w[15:8]});
  endtask
  task automatic send(input logic [7:0] c, input logic [7:0] wl, input logic [7:0] rl, input logic [15:0] d,
                      input logic bad);
    int n;
    @(posedge clock) #1;
    {cmd_code, cmd_write_len, cmd_read_len, cmd_start} = {c, wl, rl, 1'b1};
    @(posedge clock) #1 cmd_start = 1'b0;
    if (wl == LEN_SET) begin
      wr_valid = 1'b1;
      wr_byte  = d[7:0];
      @(posedge clock) #1 wr_byte = d[15:8];
      @(posedge clock) #1 wr_valid = 1'b0;
    end
    n = 0;
    while (reply_done !== 1'b1 && n < 60) begin
      @(posedge clock) #1;
      n++;
    end
    if (n == 60) begin
      num_errors++;
      conclude;
    end
    if (wl == LEN_SET) check({15'h0, reply_fcs_bad}, {15'h0, bad});
    check(16'(expq.size()), 16'h0000);
  endtask
  task automatic readall;
    for (int c = 0; c < 3; c++) begin
      expw(temp(c));
      send(8'(c), LEN_QUERY, LEN_WORD, 16'h0, 1'b0);
      expw(volt(c));
      send(CODE_SUPPLY_VOLT + 8'(c), LEN_QUERY, LEN_WORD, 16'h0, 1'b0);
    end
    for (int c = 0; c < 3; c++) expw(temp(c));
    send(CODE_LOCAL_TEMP, LEN_QUERY, LEN_BLOCK, 16'h0, 1'b0);
    for (int c = 0; c < 3; c++) expw(volt(c));
    send(CODE_SUPPLY_VOLT, LEN_QUERY, LEN_BLOCK, 16'h0, 1'b0);
    for (int i = 0; i < 2; i++) begin
      expw(corr[i]);
      send(CODE_CORR1 + 8'(i), LEN_QUERY, LEN_WORD, 16'h0, 1'b0);
    end
  endtask
  function automatic logic [15:0] volt(input int c);
    return {4'h0, 3'(c + 3), 7'h2B, 2'b00};
  endfunction
  // consumer stalls one cycle in four
  always @(posedge clock) begin
    #1;
    ph       = ph + 2'h1;
    rd_ready = (ph != 2'h0);
  end
  always @(posedge clock) if (nrst && rd_valid && rd_ready)
    check({8'h00, rd_byte}, expq.size() ? expq.pop_front() : 16'hDEAD);
  initial begin
    repeat (100000) @(posedge clock);
    num_errors++;
    conclude;
  end
  initial begin
    {nrst, cmd_start, wr_valid, diode1_fault, diode2_fault, rd_ready, ph} = 8'h0;
    {cmd_code, cmd_write_len, cmd_read_len, wr_byte} = 32'h0;
    corr[0] = 16'h0000;
    corr[1] = 16'h0000;
    repeat (20) @(posedge clock);
    #1 nrst = 1'b1;
    repeat (3000) @(posedge clock);
    readall;
    for (int i = 0; i < 2; i++) begin
      corr[i] = i ? 16'h8001 : rnd();
      send(CODE_CORR1 + 8'(i), LEN_SET, 8'h00, corr[i], 1'b0);
      corr[i] = clampc(corr[i]);
    end
    repeat (2500) @(posedge clock);
    readall;
    for (int k = 0; k < 8; k++) begin
      code = codes[k];
      if (k == 4) code = 8'(rnd() % 16'h00CB) + CODE_QUIET_LO;
      send(code, LEN_SET, 8'h00, rnd(), code >= CODE_RSVD_LO);
    end
    readall;
    diode1_fault = 1'b1;
    repeat (2500) @(posedge clock);
    readall;
    {diode1_fault, diode2_fault} = 2'b01;
    repeat (2500) @(posedge clock);
    readall;
    conclude;
  end
endmodule
`default_nettype wire
